// ===== pkg/asr_pkg.sv
// Functional notes
// (RULE1) Identification word bits 11:8 always read channel quantity three.
// (RULE2) Identification low byte is reserved; its value is not guaranteed.
// (RULE3) Status bit 15 set by lock command, cleared by unlock, resets 0.
// (RULE4) Status bit 14 set on each resync; cleared by status read.
// (RULE5) Status bit 13 set on register-map checksum fault; cleared by status read.
// (RULE6) Status bit 12 set on serial input checksum error; cleared by status read.
// (RULE7) Status bit 11 shows checksum polynomial, 1 meaning ANSI; resets 0.
// (RULE8) Status bit 10 set by reset pin, power-on or reset command.
// (RULE9) Reset bit clears only by writing 0 to mode reset field.
// (RULE10) Status bits 9:8 show sample word size; reset value 01.
// (RULE11) Status bit 7 fuse parity fault; read clears; persisting fault sets again.
// (RULE12) Status bit 6 isolated supply fault; resets 1; cleared by status read.
// (RULE13) Status bits 5:3 always read zero.
// (RULE14) Status bits 2:0 show new sample per channel; reset 0.
// (RULE15) Status word sits at address one and reads 0540 after reset.
// (RULE16) Host writes 0 to mode bit 10 to clear reset indication.
// (RULE17) Status polynomial bit follows mode register bit 11.
// (RULE18) Status word size bits mirror mode register bits 9:8.
// (RULE19) Writes to identification or status words change nothing.
package asr_pkg;
    localparam int ADDR_W = 6;
    localparam logic [ADDR_W-1:0] ID_ADDR = 6'h00;
    localparam logic [ADDR_W-1:0] STATUS_ADDR = 6'h01;
    localparam logic [15:0] STATUS_RESET = 16'h0540;
    localparam logic [3:0] CHANNEL_QTY = 4'h3;
    localparam logic [1:0] WLEN_RESET = 2'h1;
    localparam logic CRC_TYPE_RESET = 1'b0;
    localparam logic [2:0] NEW_SAMPLE_RESET = 3'h0;
    localparam logic [2:0] STS_RSVD_VALUE = 3'h0;
    // Status bit positions
    localparam int STS_LOCK = 15;
    localparam int STS_RESYNC = 14;
    localparam int STS_REGMAP = 13;
    localparam int STS_RXCRC = 12;
    localparam int STS_CRC_TYPE = 11;
    localparam int STS_RESET = 10;
    localparam int STS_WLEN_HI = 9;
    localparam int STS_WLEN_LO = 8;
    localparam int STS_FUSE = 7;
    localparam int STS_SIDE = 6;
    localparam int STS_RSVD_HI = 5;
    localparam int STS_RSVD_LO = 3;
    // Sticky flag slots
    localparam int NFLAG = 7;
    localparam int F_LOCK = 0;
    localparam int RESYNC_EVENT_FLAG = 1;
    localparam int F_REGMAP = 2;
    localparam int F_RXCRC = 3;
    localparam int F_RESET = 4;
    localparam int F_FUSE = 5;
    localparam int F_SIDE = 6;
    localparam logic [NFLAG-1:0] FLAG_RESET = 7'h50;

    typedef struct packed {
        logic null_cmd;
        logic register_read_command;
        logic [ADDR_W-1:0] addr;
    } asr_cmd_s;

    typedef struct packed {
        logic valid;
        logic hit;
        logic [15:0] data;
    } asr_rsp_s;

    typedef struct packed {
        logic resync;
        logic regmap_fault;
        logic rx_crc_fault;
        logic lock_cmd;
        logic unlock_cmd;
        logic reset_cmd;
        logic mode_reset_clear;
    } asr_evt_s;

    typedef struct packed {
        logic crc_type;
        logic [1:0] sample_word_size;
    } asr_mode_s;

    function automatic logic is_status_read(input asr_cmd_s c);
        return c.null_cmd || (c.register_read_command && c.addr == STATUS_ADDR);
    endfunction
endpackage

// ===== verilog/asr_sticky_flag.sv
`timescale 1ns/1ps
`default_nettype none
module asr_sticky_flag
    import asr_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic set,
    input wire logic clear,
    output logic flag_q
);
    // A set in the clearing cycle wins so no event is lost
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            flag_q <= RESET_VAL;
        end else if (set) begin
            flag_q <= 1'b1;
        end else if (clear) begin
            flag_q <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// ===== verilog/asr_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module asr_status_regs
    import asr_pkg::*;
#(
    // Arbitrary identity values, not those of any real part
    parameter logic [3:0] ID_UPPER = 4'hA,
    parameter logic [7:0] ID_LOW = 8'h00
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire asr_cmd_s cmd,
    input wire asr_evt_s evt,
    input wire asr_mode_s mode,
    input wire logic [2:0] new_sample,
    input wire logic fuse_fault_pin,
    input wire logic side_fault_pin,
    output asr_rsp_s rsp,
    output logic lock_active
);
    logic fuse_meta_q;
    logic fuse_sync_q;
    logic side_meta_q;
    logic side_sync_q;
    logic crc_type_q;
    logic [1:0] word_size_q;
    logic ch2_new_sample_q;
    logic ch1_new_sample_q;
    logic ch0_new_sample_q;
    logic [NFLAG-1:0] flag_set;
    logic [NFLAG-1:0] flag_clr;
    logic [NFLAG-1:0] flag_q;
    logic [15:0] status_word;
    logic [15:0] id_word;
    logic status_rd;
    logic id_rd;
    logic any_rd;
    asr_rsp_s rsp_q;

    // Fault levels come from the analog side; two stages before use
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            fuse_meta_q <= 1'b0;
            fuse_sync_q <= 1'b0;
            side_meta_q <= 1'b0;
            side_sync_q <= 1'b0;
        end else begin
            fuse_meta_q <= fuse_fault_pin;
            fuse_sync_q <= fuse_meta_q;
            side_meta_q <= side_fault_pin;
            side_sync_q <= side_meta_q;
        end
    end

    // Mirrors of the mode register fields
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            crc_type_q <= CRC_TYPE_RESET; // RULE7
            word_size_q <= WLEN_RESET; // RULE10
        end else begin
            crc_type_q <= mode.crc_type; // RULE17
            word_size_q <= mode.sample_word_size; // RULE18
        end
    end

    // New-sample indications per channel
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            {ch2_new_sample_q, ch1_new_sample_q, ch0_new_sample_q} <= NEW_SAMPLE_RESET; // RULE14
        end else begin
            {ch2_new_sample_q, ch1_new_sample_q, ch0_new_sample_q} <= new_sample; // RULE14
        end
    end

    assign status_rd = is_status_read(cmd);
    assign id_rd = cmd.register_read_command && cmd.addr == ID_ADDR;
    assign any_rd = cmd.null_cmd || cmd.register_read_command;

    // Set and clear terms of the sticky flags
    always_comb begin
        flag_set = '0;
        flag_clr = '0;
        flag_set[F_LOCK] = evt.lock_cmd; // RULE3
        flag_clr[F_LOCK] = evt.unlock_cmd; // RULE3
        flag_set[RESYNC_EVENT_FLAG] = evt.resync; // RULE4
        flag_clr[RESYNC_EVENT_FLAG] = status_rd; // RULE4
        flag_set[F_REGMAP] = evt.regmap_fault; // RULE5
        flag_clr[F_REGMAP] = status_rd; // RULE5
        flag_set[F_RXCRC] = evt.rx_crc_fault; // RULE6
        flag_clr[F_RXCRC] = status_rd; // RULE6
        // The pin reset is covered by the flag's reset value
        flag_set[F_RESET] = evt.reset_cmd; // RULE8
        // Reads never touch this one; only the mode field write does
        flag_clr[F_RESET] = evt.mode_reset_clear; // RULE9
        // A persisting fault keeps the set term high, so it re-arms itself
        flag_set[F_FUSE] = fuse_sync_q; // RULE11
        flag_clr[F_FUSE] = status_rd; // RULE11
        flag_set[F_SIDE] = side_sync_q; // RULE12
        flag_clr[F_SIDE] = status_rd; // RULE12
    end

    for (genvar i = 0; i < NFLAG; i++) begin : g_flag
        asr_sticky_flag #(
            .RESET_VAL(FLAG_RESET[i])
        ) u_flag (
            .ref_clk(ref_clk),
            .reset_n(reset_n),
            .set(flag_set[i]),
            .clear(flag_clr[i]),
            .flag_q(flag_q[i])
        );
    end

    // Reset values of all parts together give 0540
    assign status_word = {
        flag_q[F_LOCK],
        flag_q[RESYNC_EVENT_FLAG],
        flag_q[F_REGMAP],
        flag_q[F_RXCRC],
        crc_type_q,
        flag_q[F_RESET],
        word_size_q,
        flag_q[F_FUSE],
        flag_q[F_SIDE],
        STS_RSVD_VALUE, // RULE13
        ch2_new_sample_q,
        ch1_new_sample_q,
        ch0_new_sample_q
    }; // RULE15

    assign id_word = {ID_UPPER, CHANNEL_QTY, ID_LOW}; // RULE1 RULE2

    // Read answer one cycle after the command. The returned word is the
    // value before the read-clear, so an event is reported exactly once.
    // There is no write path: neither word can be altered from the host.
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rsp_q <= '0;
        end else begin
            rsp_q.valid <= any_rd;
            rsp_q.hit <= status_rd || id_rd;
            if (status_rd) begin
                rsp_q.data <= status_word; // RULE15 RULE19
            end else if (id_rd) begin
                rsp_q.data <= id_word; // RULE1
            end else begin
                rsp_q.data <= 16'h0000;
            end
        end
    end

    assign rsp = rsp_q;
    assign lock_active = flag_q[F_LOCK];

    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);

    sequence s_status_read;
        cmd.null_cmd || (cmd.register_read_command && cmd.addr == STATUS_ADDR);
    endsequence

    sequence s_id_read;
        cmd.register_read_command && cmd.addr == ID_ADDR && !cmd.null_cmd;
    endsequence

    sequence s_fuse_steady;
        fuse_fault_pin [*3];
    endsequence

    sequence s_side_quiet;
        !side_fault_pin [*3];
    endsequence

    sequence s_fuse_quiet;
        !fuse_fault_pin [*3];
    endsequence

    sequence s_side_steady;
        side_fault_pin [*3];
    endsequence

    sequence s_miss_read;
        cmd.register_read_command && !cmd.null_cmd
            && cmd.addr != ID_ADDR && cmd.addr != STATUS_ADDR;
    endsequence

    sequence s_no_command;
        !cmd.null_cmd && !cmd.register_read_command;
    endsequence

    id_count_a: assert property ( // RULE1
        s_id_read |=> rsp.valid && rsp.hit && rsp.data[11:8] == CHANNEL_QTY)
        else $error("channel quantity field wrong");

    lock_set_a: assert property ( // RULE3
        evt.lock_cmd |=> status_word[STS_LOCK] && lock_active)
        else $error("lock command did not set lock bit");

    lock_clear_a: assert property ( // RULE3
        evt.unlock_cmd && !evt.lock_cmd |=> !status_word[STS_LOCK])
        else $error("unlock command did not clear lock bit");

    lock_hold_a: assert property ( // RULE3
        status_word[STS_LOCK] && !evt.unlock_cmd |=> status_word[STS_LOCK])
        else $error("lock bit dropped without unlock");

    resync_set_a: assert property ( // RULE4
        evt.resync |=> status_word[STS_RESYNC])
        else $error("resync flag not set");

    resync_clear_a: assert property ( // RULE4
        s_status_read and !evt.resync |=> !status_word[STS_RESYNC])
        else $error("resync flag not cleared by status read");

    regmap_flag_a: assert property ( // RULE5
        evt.regmap_fault |=> status_word[STS_REGMAP])
        else $error("register map fault not flagged");

    regmap_clear_a: assert property ( // RULE5
        s_status_read and !evt.regmap_fault |=> !status_word[STS_REGMAP])
        else $error("register map flag not cleared by read");

    rxcrc_flag_a: assert property ( // RULE6
        evt.rx_crc_fault |=> status_word[STS_RXCRC])
        else $error("input checksum error not flagged");

    rxcrc_clear_a: assert property ( // RULE6
        s_status_read and !evt.rx_crc_fault |=> !status_word[STS_RXCRC])
        else $error("input checksum flag not cleared by read");

    crc_type_a: assert property ( // RULE7 RULE17
        ##1 status_word[STS_CRC_TYPE] == $past(mode.crc_type))
        else $error("polynomial bit does not follow mode");

    reset_cmd_a: assert property ( // RULE8
        evt.reset_cmd |=> status_word[STS_RESET])
        else $error("reset command did not set reset bit");

    reset_sticky_a: assert property ( // RULE9
        status_word[STS_RESET] && !evt.mode_reset_clear |=> status_word[STS_RESET])
        else $error("reset bit cleared without mode write");

    reset_clear_a: assert property ( // RULE9
        evt.mode_reset_clear && !evt.reset_cmd |=> !status_word[STS_RESET])
        else $error("mode write did not clear reset bit");

    word_size_a: assert property ( // RULE10 RULE18
        ##1 status_word[STS_WLEN_HI:STS_WLEN_LO] == $past(mode.sample_word_size))
        else $error("word size bits do not mirror mode");

    fuse_rearm_a: assert property ( // RULE11
        s_fuse_steady |=> status_word[STS_FUSE] [*2])
        else $error("persisting fuse fault not flagged");

    side_clear_a: assert property ( // RULE12
        s_side_quiet ##0 s_status_read |=> !status_word[STS_SIDE])
        else $error("supply fault flag not cleared by read");

    reserved_zero_a: assert property ( // RULE13
        status_word[STS_RSVD_HI:STS_RSVD_LO] == STS_RSVD_VALUE
            && (!rsp.hit || rsp.data[15:12] == ID_UPPER || rsp.data[5:3] == 3'h0))
        else $error("reserved status bits not zero");

    new_sample_a: assert property ( // RULE14
        ##1 status_word[2:0] == $past(new_sample))
        else $error("new sample bits do not follow channels");

    status_read_a: assert property ( // RULE15
        s_status_read |=> rsp.valid && rsp.hit && rsp.data == $past(status_word))
        else $error("status read returned wrong word");

    // Read-clear flags only drop on a status read
    resync_hold_a: assert property ( // RULE4
        status_word[STS_RESYNC] && !status_rd |=> status_word[STS_RESYNC])
        else $error("resync flag dropped without status read");

    regmap_hold_a: assert property ( // RULE5
        status_word[STS_REGMAP] && !status_rd |=> status_word[STS_REGMAP])
        else $error("register map flag dropped without status read");

    regmap_wins_a: assert property ( // RULE5
        evt.regmap_fault && status_rd |=> status_word[STS_REGMAP])
        else $error("register map fault lost in read cycle");

    rxcrc_hold_a: assert property ( // RULE6
        status_word[STS_RXCRC] && !status_rd |=> status_word[STS_RXCRC])
        else $error("input checksum flag dropped without status read");

    fuse_hold_a: assert property ( // RULE11
        status_word[STS_FUSE] && !status_rd |=> status_word[STS_FUSE])
        else $error("fuse flag dropped without status read");

    fuse_wins_a: assert property ( // RULE11
        fuse_sync_q && status_rd |=> status_word[STS_FUSE])
        else $error("persisting fuse fault cleared by read");

    fuse_clear_a: assert property ( // RULE11
        s_fuse_quiet ##0 s_status_read |=> !status_word[STS_FUSE])
        else $error("fuse flag not cleared by read");

    side_hold_a: assert property ( // RULE12
        status_word[STS_SIDE] && !status_rd |=> status_word[STS_SIDE])
        else $error("supply fault flag dropped without status read");

    side_wins_a: assert property ( // RULE12
        side_sync_q && status_rd |=> status_word[STS_SIDE])
        else $error("persisting supply fault cleared by read");

    side_rearm_a: assert property ( // RULE12
        s_side_steady |=> status_word[STS_SIDE] [*2])
        else $error("persisting supply fault not flagged");

    // Answer path: one word per command, nothing for idle cycles
    miss_read_a: assert property ( // RULE19
        s_miss_read |=> rsp.valid && !rsp.hit && rsp.data == 16'h0000)
        else $error("unmapped read returned data");

    idle_quiet_a: assert property ( // RULE15
        s_no_command |=> !rsp.valid)
        else $error("answer without a command");

    valid_source_a: assert property ( // RULE15
        rsp.valid |-> $past(any_rd))
        else $error("answer not caused by a read");

    hit_valid_a: assert property ( // RULE15
        rsp.hit |-> rsp.valid)
        else $error("hit shown without an answer");

    id_low_a: assert property ( // RULE2
        s_id_read |=> rsp.data[15:12] == ID_UPPER && rsp.data[7:0] == ID_LOW)
        else $error("identification word fields wrong");

    lock_read_a: assert property ( // RULE3
        s_status_read and !evt.lock_cmd && !evt.unlock_cmd
            |=> rsp.data[STS_LOCK] == lock_active)
        else $error("lock bit read back differs from lock output");

    rsp_reserved_a: assert property ( // RULE13
        s_status_read |=> rsp.data[STS_RSVD_HI:STS_RSVD_LO] == STS_RSVD_VALUE)
        else $error("reserved bits read back not zero");

    // Reset check opts out of the default disable to see the release edge
    reset_word_a: assert property (disable iff (1'b0) // RULE15
        $rose(reset_n) |-> status_word == STATUS_RESET && !lock_active && !rsp.valid)
        else $error("status word wrong after reset");
endmodule
`default_nettype wire

// ===== tb/asr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module asr_host_model
    import asr_pkg::*;
(
    input wire logic ref_clk,
    input wire asr_rsp_s rsp,
    output asr_cmd_s cmd,
    output logic mode_clear
);
    initial begin
        cmd = '0;
        mode_clear = 1'b0;
    end

    // Command held from one falling edge to the next, so the taking edge sees it whole
    task automatic read(input logic nul, input logic [ADDR_W-1:0] a, output asr_rsp_s r);
        int i;
        @(negedge ref_clk);
        cmd.null_cmd = nul;
        cmd.register_read_command = !nul;
        cmd.addr = a;
        @(negedge ref_clk);
        cmd.null_cmd = 1'b0;
        cmd.register_read_command = 1'b0;
        // Released address shows a changing pattern rather than the last value
        cmd.addr = ~a;
        r = rsp;
        for (i = 0; i < 3 && r.valid !== 1'b1; i++) begin
            @(negedge ref_clk);
            r = rsp;
        end
    endtask

    task automatic clear_reset();
        @(negedge ref_clk);
        mode_clear = 1'b1;
        @(negedge ref_clk);
        mode_clear = 1'b0;
    endtask
endmodule
`default_nettype wire

// ===== tb/test_adc_status_id_registers.sv
`timescale 1ns/1ps
`default_nettype none
module test_adc_status_id_registers
    import asr_pkg::*;
;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    asr_cmd_s cmd;
    asr_evt_s evt = '0;
    asr_evt_s evt_all;
    asr_mode_s mode = 3'h1;
    logic [2:0] new_sample = 3'h0;
    logic fuse_pin = 1'b0;
    logic side_pin = 1'b0;
    logic mode_clear;
    asr_rsp_s rsp;
    logic lock_active;
    int n_mismatch = 0;
    int tests_run = 0;
    int seed = 32'hB4EB;
    logic m_lock, m_resync, m_regmap, m_rxcrc, m_rst, m_fuse, m_side;

    always #4 ref_clk = ~ref_clk;

    always_comb begin
        evt_all = evt;
        evt_all.mode_reset_clear = mode_clear;
    end

    // Identity nibble value is arbitrary
    asr_status_regs #(.ID_UPPER(4'h5), .ID_LOW(8'h00)) i_dut (
        .ref_clk(ref_clk), .reset_n(reset_n), .cmd(cmd), .evt(evt_all), .mode(mode),
        .new_sample(new_sample), .fuse_fault_pin(fuse_pin), .side_fault_pin(side_pin),
        .rsp(rsp), .lock_active(lock_active)
    );

    asr_host_model i_host (.ref_clk(ref_clk), .rsp(rsp), .cmd(cmd), .mode_clear(mode_clear));

    function automatic logic [15:0] exp_status();
        return {m_lock, m_resync, m_regmap, m_rxcrc, mode.crc_type, m_rst,
                mode.sample_word_size, m_fuse, m_side, 3'h0, new_sample};
    endfunction

    task automatic check(input logic [16:0] seen, input logic [16:0] want);
        tests_run++;
        if (seen !== want) begin
            n_mismatch++;
            $display("wrong value at time %0t seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic model_reset();
        {m_lock, m_resync, m_regmap, m_rxcrc, m_fuse} = '0;
        m_rst = 1'b1;
        m_side = 1'b1;
    endtask

    task automatic read_status(input logic nul);
        asr_rsp_s r;
        i_host.read(nul, STATUS_ADDR, r);
        check({r.hit, r.data}, {1'b1, exp_status()});
        check({r.valid, lock_active}, {1'b1, m_lock});
        {m_resync, m_regmap, m_rxcrc} = '0;
        // A fault level still present sets its flag again at once
        m_fuse = fuse_pin;
        m_side = side_pin;
    endtask

    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        #100000;
        n_mismatch++;
        summarize();
    end

    initial begin
        logic [31:0] ev;
        asr_rsp_s r;
        model_reset();
        repeat (12) @(negedge ref_clk);
        reset_n = 1'b1;
        read_status(1'b1);
        read_status(1'b0);
        $display("reset value test done");
        for (int it = 0; it < 80; it++) begin
            ev = $random(seed);
            @(negedge ref_clk);
            evt = asr_evt_s'({ev[5:0], 1'b0});
            mode = asr_mode_s'(ev[8:6]);
            new_sample = ev[11:9];
            fuse_pin = ev[12] & ev[13];
            side_pin = ev[14] & ev[15];
            m_resync |= ev[5];
            m_regmap |= ev[4];
            m_rxcrc |= ev[3];
            // Lock and unlock together: lock wins
            if (ev[2]) m_lock = 1'b1;
            else if (ev[1]) m_lock = 1'b0;
            m_rst |= ev[0];
            m_fuse |= fuse_pin;
            m_side |= side_pin;
            @(negedge ref_clk);
            evt = '0;
            if (ev[16]) begin
                i_host.clear_reset();
                m_rst = 1'b0;
            end
            repeat (4) @(negedge ref_clk);
            case (ev[18:17])
                2'h0, 2'h1: read_status(ev[17]);
                2'h2: begin
                    i_host.read(1'b0, ID_ADDR, r);
                    // Low byte is not relied on
                    check({r.hit, r.data[15:8], 8'h00}, {1'b1, 4'h5, 4'h3, 8'h00});
                end
                default: begin
                    i_host.read(1'b0, ev[24:19] | 6'h02, r);
                    check({r.hit, r.data}, 17'h0);
                end
            endcase
        end
        $display("random mix test done");
        @(negedge ref_clk);
        evt = asr_evt_s'(7'h78);
        @(negedge ref_clk);
        evt = '0;
        mode = 3'h1;
        new_sample = 3'h0;
        fuse_pin = 1'b0;
        side_pin = 1'b0;
        repeat (5) @(negedge ref_clk);
        reset_n = 1'b0;
        repeat (12) @(negedge ref_clk);
        reset_n = 1'b1;
        model_reset();
        read_status(1'b0);
        $display("second reset test done");
        summarize();
    end
endmodule
`default_nettype wire
